/* File: verilog/carrier_pkg.sv */
// Shared constants, types and address decode of the carrier local control.
// Assumes a 100 MHz local clock and a 16-bit local bus byte address.
package carrier_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [15:0] CTRL_OFFSET = 16'h0500;
    localparam logic [15:0] PENDING_OFFSET = 16'h0600;
    localparam logic [15:0] STATUS_OFFSET = 16'h0700;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PENDING_RESET = 8'h00;
    localparam int ARM_BIT = 4;
    localparam int AUTO_ACK_BIT = 5;
    localparam int IRQ_EN_BIT = 6;
    localparam int FORCE_BIT = 7;
    localparam int STAT_IRQ_BIT = 0;
    localparam int STAT_FLAG_BIT = 1;
    localparam logic [15:0] TIMEOUT_READ_DATA = 16'hFFFF;

    ////////////////////////////////////////////////////////////////////////
    // Slot windows, reduced map
    localparam logic [3:0] SLOT_FIRST_PAGE = 4'h1;
    localparam logic [3:0] SLOT_LAST_PAGE = 4'h4;
    localparam logic [3:0] IO_NIBBLE = 4'h0;
    localparam logic [3:0] ID_NIBBLE = 4'h1;
    localparam logic [3:0] INT_NIBBLE = 4'h2;
    localparam logic [15:0] MEM_BASE = 16'h5000;
    localparam logic [15:0] MEM_WINDOW_BYTES = 16'h0800;
    localparam logic [15:0] MEM_TOTAL_BYTES = 16'h2000;
    localparam logic [1:0] SPACE_IO = 2'h0;
    localparam logic [1:0] SPACE_ID = 2'h1;
    localparam logic [1:0] SPACE_INT = 2'h2;
    localparam logic [1:0] SPACE_MEM = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMEOUT_NS = 3200;
    localparam int TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;
    localparam longint SYS_HZ = 100_000_000;
    localparam longint SLOW_HZ = 8_000_000;
    localparam longint FAST_HZ = 32_000_000;
    localparam int PHASE_W = 16;
    // Toggle rate is twice the slot clock rate
    localparam logic [PHASE_W-1:0] SLOW_INC =
        PHASE_W'((64'd2 * SLOW_HZ * (64'd1 << PHASE_W)) / SYS_HZ);
    localparam logic [PHASE_W-1:0] FAST_INC =
        PHASE_W'((64'd2 * FAST_HZ * (64'd1 << PHASE_W)) / SYS_HZ);

    typedef struct packed {
        logic ctrl;
        logic pend;
        logic stat;
        logic slot_hit;
        logic [1:0] slot;
        logic [1:0] space;
    } decode_t;

    function automatic decode_t decode_addr(input logic [15:0] a);
        decode_t d;
        logic [15:0] off;
        d = '0;
        off = a - MEM_BASE;
        d.ctrl = (a[15:1] == CTRL_OFFSET[15:1]);
        d.pend = (a[15:1] == PENDING_OFFSET[15:1]);
        d.stat = (a[15:1] == STATUS_OFFSET[15:1]);
        if (a >= MEM_BASE && off < MEM_TOTAL_BYTES) begin
            d.slot_hit = 1'b1;
            d.slot = off[12:11];
            d.space = SPACE_MEM;
        end else if (a[15:12] >= SLOT_FIRST_PAGE &&
                     a[15:12] <= SLOT_LAST_PAGE &&
                     a[11:8] <= INT_NIBBLE) begin
            d.slot_hit = 1'b1;
            d.slot = 2'(a[15:12] - SLOT_FIRST_PAGE);
            d.space = a[9:8];
        end
        return d;
    endfunction

endpackage

/* File: verilog/pin_sync.sv */
// Three-stage synchroniser for pin inputs; a bit changes once
// stages two and three agree. Assumes a synchronised active-low reset.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_sync_b,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] f1;
        logic [W-1:0] f2;
        logic [W-1:0] f3;
        logic [W-1:0] q;
    } sync_t;
    sync_t s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.f1 = pin;
        s_next.f2 = s_reg.f1;
        s_next.f3 = s_reg.f2;
        // Hold unless the two settled stages agree
        s_next.q = (s_reg.f2 & s_reg.f3) |
                   (s_reg.q & (s_reg.f2 | s_reg.f3));
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.q;
endmodule // pin_sync

/* File: verilog/slot_clock_gen.sv */
// Per-slot 8 / 32 MHz clocks from two phase accumulators, with rate
// changes taken only while a slot clock is low.
// Assumes the 100 MHz clock and a synchronised active-low reset.
`timescale 1ns/1ps
module slot_clock_gen
    import carrier_pkg::*;
#(
    parameter int SLOTS = 4
) (
    input wire logic clk,
    input wire logic rst_sync_b,
    input wire logic [SLOTS-1:0] fast_sel,
    output logic [SLOTS-1:0] slot_clk,
    output logic [SLOTS-1:0] slot_rise
);
    typedef struct packed {
        logic [PHASE_W-1:0] slow_acc;
        logic [PHASE_W-1:0] fast_acc;
        logic [SLOTS-1:0] clk_q;
        logic [SLOTS-1:0] use_fast;
        logic [SLOTS-1:0] rise;
    } clkgen_t;
    clkgen_t s_reg, s_next;

    always_comb begin
        logic [PHASE_W:0] slow_sum;
        logic [PHASE_W:0] fast_sum;
        logic tick;
        slow_sum = {1'b0, s_reg.slow_acc} + {1'b0, SLOW_INC};
        fast_sum = {1'b0, s_reg.fast_acc} + {1'b0, FAST_INC};
        tick = 1'b0;
        s_next = s_reg;
        s_next.slow_acc = slow_sum[PHASE_W-1:0];
        s_next.fast_acc = fast_sum[PHASE_W-1:0];
        for (int i = 0; i < SLOTS; i++) begin
            tick = s_reg.use_fast[i] ? fast_sum[PHASE_W] : slow_sum[PHASE_W];
            s_next.rise[i] = tick & ~s_reg.clk_q[i];
            if (tick) begin
                s_next.clk_q[i] = ~s_reg.clk_q[i];
                // Switch only on a falling edge: no runt pulse
                if (s_reg.clk_q[i]) begin
                    s_next.use_fast[i] = fast_sel[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign slot_clk = s_reg.clk_q;
    assign slot_rise = s_reg.rise;

    chk_rate_switch_low: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        s_reg.use_fast[0] != $past(s_reg.use_fast[0]) |-> !s_reg.clk_q[0])
        else $error("slot rate changed while slot clock high");
endmodule // slot_clock_gen

/* File: verilog/carrier_local_control.sv */
// Local control of a four-slot module carrier behind a bus bridge.
// Assumes the bridge holds lb_req and its fields steady until lb_ack,
// then drops lb_req; module pins come from outside the clock domain.
// Contract
// - Decode a 2 KByte memory window per slot in the reduced map.
// - Merge every module interrupt onto the one host interrupt line.
// - Show eight module requests as pending bits, slot A line 0 in D0.
// - Raise the host interrupt when a pending bit is set and enabled.
// - Pending bits ignore writes; they clear when the module withdraws.
// - A read of interrupt space runs an acknowledge cycle on the module.
// - Module A1 follows host A1 in interrupt space, selecting the line.
// - Interrupt space may be accessed at any time, no enable needed.
// - With reply enabled, answer a silent or empty slot after 3.2 us.
// - Auto-reply only for decoded module addresses, never others.
// - Timeout flag held clear while arm is 0, sets on auto-reply.
// - Timeout flag stays set until software writes arm to 0.
// - Unanswered access interrupts when arm, reply and enable are set.
// - Without auto-reply a silent module leaves the access pending.
// - Each slot runs at 8 or 32 MHz by its select bit, D0 to D3.
// - Access sequencing follows the addressed slot's clock rate.
// - Slot clock rate changes are free of glitches.
// - Control register is read-write, resets to 0x00, D4 to D7 as set.
// - With interrupts disabled, sources stay pending but unseen.
// - Forced interrupt bit drives the bridge interrupt when enabled.
`timescale 1ns/1ps
module carrier_local_control
    import carrier_pkg::*;
#(
    parameter int TIMEOUT_COUNT = TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic lb_req,
    input wire logic lb_wr,
    input wire logic [15:0] lb_addr,
    input wire logic [15:0] lb_wdata,
    output logic [15:0] lb_rdata,
    output logic lb_ack,
    output logic local_irq,
    output logic [3:0] slot_clk,
    output logic [3:0] io_sel_b,
    output logic [3:0] id_sel_b,
    output logic [3:0] int_sel_b,
    output logic [3:0] mem_sel_b,
    output logic mod_rw_b,
    output logic [10:1] mod_addr,
    output logic [15:0] mod_data_out,
    output logic mod_data_oe,
    input wire logic [15:0] mod_data_in,
    input wire logic [3:0] mod_ack_b,
    input wire logic [7:0] mod_irq_b
);
    localparam int TW = $clog2(TIMEOUT_COUNT + 1);
    localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT_COUNT - 1);
    localparam int REPLY_BOUND = 420;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_WAIT,
        ST_FINISH
    } access_t;

    typedef struct packed {
        access_t fsm;
        logic [7:0] ctrl;
        logic flag;
        logic [7:0] pend;
        logic [1:0] slot;
        logic [1:0] space;
        logic wr;
        logic [10:1] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic ack;
        logic sel;
        logic oe;
        logic [TW-1:0] tmo;
        logic irq;
        logic fired;
    } state_t;

    state_t s_reg, s_next;
    logic [1:0] rst_pipe;
    logic rst_sync_b;
    logic [3:0] ack_sync_b;
    logic [7:0] irq_sync_b;
    logic [15:0] data_sync;
    logic [3:0] slot_rise;
    decode_t dec;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_pipe[1];

    // Data shares the three-stage path so it lines up with acknowledge
    pin_sync #(
        .W(28),
        .RESET_VAL({4'hF, 8'hFF, 16'h0000})
    ) u_pin_sync (
        .clk(clk),
        .rst_sync_b(rst_sync_b),
        .pin({mod_ack_b, mod_irq_b, mod_data_in}),
        .q({ack_sync_b, irq_sync_b, data_sync})
    );

    slot_clock_gen #(
        .SLOTS(4)
    ) u_slot_clock_gen (
        .clk(clk),
        .rst_sync_b(rst_sync_b),
        .fast_sel(s_reg.ctrl[3:0]),
        .slot_clk(slot_clk),
        .slot_rise(slot_rise)
    );

    assign dec = decode_addr(lb_addr);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic fire;
        fire = 1'b0;
        s_next = s_reg;
        s_next.ack = 1'b0;
        case (s_reg.fsm)
            ST_IDLE: begin
                // s_reg.ack guards against retaking the request just answered
                if (lb_req && !s_reg.ack) begin
                    if (dec.ctrl) begin
                        if (lb_wr) begin
                            s_next.ctrl = lb_wdata[7:0];
                        end
                        s_next.rdata = {8'h00, s_reg.ctrl};
                        s_next.ack = 1'b1;
                    end else if (dec.pend) begin
                        // Writes land nowhere here
                        s_next.rdata = {8'h00, s_reg.pend};
                        s_next.ack = 1'b1;
                    end else if (dec.stat) begin
                        s_next.rdata = 16'h0000;
                        s_next.rdata[STAT_IRQ_BIT] = s_reg.irq;
                        s_next.rdata[STAT_FLAG_BIT] = s_reg.flag;
                        s_next.ack = 1'b1;
                    end else if (dec.slot_hit) begin
                        // Interrupt space needs no enable
                        s_next.slot = dec.slot;
                        s_next.space = dec.space;
                        s_next.wr = lb_wr;
                        s_next.addr = lb_addr[10:1];
                        if (dec.space != SPACE_MEM) begin
                            s_next.addr[10:8] = 3'h0;
                        end
                        s_next.wdata = lb_wdata;
                        s_next.tmo = '0;
                        s_next.fsm = ST_SETUP;
                    end
                    // Anything else gets no answer at all
                end
            end
            ST_SETUP: begin
                if (slot_rise[s_reg.slot]) begin
                    s_next.sel = 1'b1;
                    s_next.oe = s_reg.wr;
                    s_next.fsm = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!ack_sync_b[s_reg.slot]) begin
                    s_next.rdata = data_sync;
                    s_next.fsm = ST_FINISH;
                end else if (s_reg.ctrl[AUTO_ACK_BIT] &&
                             s_reg.tmo >= TIMEOUT_LAST) begin
                    fire = 1'b1;
                    s_next.rdata = TIMEOUT_READ_DATA;
                    s_next.fsm = ST_FINISH;
                end else begin
                    // No answer yet: count toward the timeout; without reply enabled, wait as long as it takes
                    if (s_reg.tmo < TIMEOUT_LAST) begin
                        s_next.tmo = s_reg.tmo + 1'b1;
                    end
                end
            end
            ST_FINISH: begin
                if (slot_rise[s_reg.slot]) begin
                    s_next.sel = 1'b0;
                    s_next.oe = 1'b0;
                    s_next.ack = 1'b1;
                    s_next.fsm = ST_IDLE;
                end
            end
            default: begin
                s_next.fsm = ST_IDLE;
                s_next.sel = 1'b0;
                s_next.oe = 1'b0;
            end
        endcase
        s_next.fired = fire;
        // Clearing arm beats a same-cycle timeout: flag is held clear
        s_next.flag = s_next.ctrl[ARM_BIT] & (s_reg.flag | fire);
        s_next.pend = ~irq_sync_b;
        // One line carries all sources
        s_next.irq = s_next.ctrl[IRQ_EN_BIT] &
                     ((|s_next.pend) | s_next.flag |
                      s_next.ctrl[FORCE_BIT]);
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s_reg <= '0;
            s_reg.fsm <= ST_IDLE;
            s_reg.ctrl <= CTRL_RESET;
            s_reg.pend <= PENDING_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sel
            logic hit;
            assign hit = s_reg.sel && (s_reg.slot == 2'(g));
            assign io_sel_b[g] = !(hit && s_reg.space == SPACE_IO);
            assign id_sel_b[g] = !(hit && s_reg.space == SPACE_ID);
            assign int_sel_b[g] = !(hit && s_reg.space == SPACE_INT);
            assign mem_sel_b[g] = !(hit && s_reg.space == SPACE_MEM);
        end
    endgenerate

    assign lb_ack = s_reg.ack;
    assign lb_rdata = s_reg.rdata;
    assign local_irq = s_reg.irq;
    assign mod_rw_b = !s_reg.wr;
    assign mod_addr = s_reg.addr;
    assign mod_data_out = s_reg.wdata;
    assign mod_data_oe = s_reg.oe;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_irq_from_pending: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        (|s_reg.pend) && s_reg.ctrl[IRQ_EN_BIT] |-> local_irq)
        else $error("pending request not presented");

    chk_irq_blocked_off: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        !s_reg.ctrl[IRQ_EN_BIT] |-> !local_irq)
        else $error("interrupt presented while disabled");

    chk_forced_irq_drive: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        s_reg.ctrl[IRQ_EN_BIT] && s_reg.ctrl[FORCE_BIT] |-> local_irq)
        else $error("forced interrupt not driven");

    chk_flag_held_clear: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        !s_reg.ctrl[ARM_BIT] |-> !s_reg.flag)
        else $error("timeout flag set while unarmed");

    chk_flag_sticky_set: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        s_reg.flag |=> s_reg.flag || !s_reg.ctrl[ARM_BIT])
        else $error("timeout flag dropped while armed");

    chk_flag_on_fire: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        s_reg.fired && s_reg.ctrl[ARM_BIT] |-> s_reg.flag)
        else $error("timeout flag not set on auto reply");

    chk_timeout_reply_bound: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        $rose(s_reg.fsm == ST_WAIT) && s_reg.ctrl[AUTO_ACK_BIT] &&
        $stable(s_reg.ctrl[AUTO_ACK_BIT]) |-> ##[1:REPLY_BOUND] lb_ack)
        else $error("auto reply not given in time");

    chk_no_reply_undecoded: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        s_reg.fsm == ST_IDLE && lb_req && !s_reg.ack &&
        !(dec.ctrl || dec.pend || dec.stat || dec.slot_hit) |=> !lb_ack)
        else $error("undecoded access answered");

    chk_no_reply_disabled: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        s_reg.fsm == ST_WAIT && !s_reg.ctrl[AUTO_ACK_BIT] &&
        ack_sync_b[s_reg.slot] |=> s_reg.fsm == ST_WAIT)
        else $error("silent access completed without auto reply");

    chk_int_a1_follow: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        s_reg.fsm == ST_IDLE && lb_req && !s_reg.ack && dec.slot_hit &&
        dec.space == SPACE_INT |=> mod_addr[1] == $past(lb_addr[1]))
        else $error("interrupt line select not taken from A1");

    chk_pending_write_ignored: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        $stable(irq_sync_b) |=> s_reg.pend == ~$past(irq_sync_b))
        else $error("pending bits moved without module change");

    chk_ctrl_reset_zero: assert property (
        @(posedge clk)
        $rose(rst_sync_b) |-> s_reg.ctrl == CTRL_RESET)
        else $error("control register not zero after reset");

    chk_ctrl_write_lands: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        s_reg.fsm == ST_IDLE && lb_req && !s_reg.ack && dec.ctrl && lb_wr
        |=> s_reg.ctrl == $past(lb_wdata[7:0]))
        else $error("control write did not land");

    chk_select_on_tick: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        $rose(s_reg.sel) |-> $past(slot_rise[s_reg.slot]))
        else $error("module select off the slot clock");

    chk_int_read_select: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        s_reg.sel && s_reg.space == SPACE_INT && !s_reg.wr |->
            !int_sel_b[s_reg.slot] && mod_rw_b)
        else $error("interrupt read not run on the module");

    chk_read_bus_released: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        mod_data_oe |-> !mod_rw_b)
        else $error("module data driven during a read");

    chk_flag_raises_irq: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        s_reg.flag && s_reg.ctrl[IRQ_EN_BIT] |-> local_irq)
        else $error("timeout flag not presented");

    chk_ack_one_cycle: assert property (
        @(posedge clk) disable iff (!rst_sync_b)
        lb_ack |=> !lb_ack)
        else $error("local acknowledge longer than one cycle");
endmodule // carrier_local_control

/* File: verification/slot_bus_model.sv */
// Behavioural model of the four module slots on the module bus.
// Assumes selects and mod_addr come from the carrier; clk is its time base.
`timescale 1ns/1ps
module slot_bus_model (
    input wire logic clk,
    input wire logic [3:0] io_sel_b,
    input wire logic [3:0] id_sel_b,
    input wire logic [3:0] int_sel_b,
    input wire logic [3:0] mem_sel_b,
    input wire logic [10:1] mod_addr,
    input wire logic [3:0] present,
    output logic [15:0] mod_data_in,
    output logic [3:0] mod_ack_b
);
    logic [3:0] sel;
    logic [2:0] wait_cnt;

    assign sel = ~(io_sel_b & id_sel_b & int_sel_b & mem_sel_b);

    function automatic logic [1:0] space(input int s);
        if (!mem_sel_b[s]) return 2'h3;
        if (!int_sel_b[s]) return 2'h2;
        return {1'b0, !id_sel_b[s]};
    endfunction

    initial begin
        mod_ack_b = 4'hF;
        mod_data_in = 16'h0000;
        wait_cnt = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        wait_cnt <= ((sel & present) != 4'h0) ? wait_cnt + 3'h1 : 3'h0;
        // Undriven data toggles so a stale value never looks valid
        if (mod_ack_b == 4'hF) begin
            mod_data_in <= ~mod_data_in;
        end
        for (int s = 0; s < 4; s++) begin
            if (!sel[s]) begin
                mod_ack_b[s] <= 1'b1;
            end else if (present[s] && wait_cnt == 3'h4) begin
                // Vector names space, slot and line
                mod_ack_b[s] <= 1'b0;
                mod_data_in <= {4'hA, space(s), 2'(s), 7'h00, mod_addr[1]};
            end
        end
    end
endmodule // slot_bus_model

/* File: verification/tb.sv */
// Self-checking bench of the carrier local control.
// Assumes slot C is empty; the timeout is shortened to 20 cycles.
`timescale 1ns/1ps
module tb;
    import carrier_pkg::*;
    typedef struct packed {
        logic w;
        logic [15:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } row_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic lb_req = 1'b0;
    logic lb_wr = 1'b0;
    logic [15:0] lb_addr = 16'h0000;
    logic [15:0] lb_wdata = 16'h0000;
    logic [7:0] mod_irq_b = 8'hFF;
    logic [3:0] present = 4'hB;
    logic [15:0] lb_rdata, mod_data_out, mod_data_in, q;
    logic lb_ack, local_irq, mod_rw_b, mod_data_oe;
    logic [3:0] slot_clk, io_sel_b, id_sel_b, int_sel_b, mem_sel_b;
    logic [3:0] mod_ack_b;
    logic [10:1] mod_addr;
    int errors = 0;
    int total_checks = 0;
    row_t rows[7] = '{
        '{1'b1, 16'h0500, 16'hFFB5, 16'h0000},
        '{1'b0, 16'h0500, 16'h0000, 16'h00B5},
        '{1'b1, 16'h0600, 16'h00FF, 16'h0000},
        '{1'b0, 16'h0600, 16'h0000, 16'h0000},
        '{1'b0, 16'h0700, 16'h0000, 16'h0000},
        '{1'b0, 16'h0501, 16'h0000, 16'h00B5},
        '{1'b1, 16'h0500, 16'h0000, 16'h0000}};
    logic [15:0] maddr[6] = '{16'h1200, 16'h1202, 16'h4202, 16'h2102,
        16'h5802, 16'h6802};
    logic [15:0] mvec[6] = '{16'hA800, 16'hA801, 16'hAB01, 16'hA501,
        16'hAD01, 16'hAF01};

    carrier_local_control #(.TIMEOUT_COUNT(20)) i_carrier_local_control (
        .clk(clk), .rst_b(rst_b), .lb_req(lb_req), .lb_wr(lb_wr),
        .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_rdata(lb_rdata),
        .lb_ack(lb_ack), .local_irq(local_irq), .slot_clk(slot_clk),
        .io_sel_b(io_sel_b), .id_sel_b(id_sel_b), .int_sel_b(int_sel_b),
        .mem_sel_b(mem_sel_b), .mod_rw_b(mod_rw_b), .mod_addr(mod_addr),
        .mod_data_out(mod_data_out), .mod_data_oe(mod_data_oe),
        .mod_data_in(mod_data_in), .mod_ack_b(mod_ack_b),
        .mod_irq_b(mod_irq_b));

    slot_bus_model i_slot_bus_model (
        .clk(clk), .io_sel_b(io_sel_b), .id_sel_b(id_sel_b),
        .int_sel_b(int_sel_b), .mem_sel_b(mem_sel_b), .mod_addr(mod_addr),
        .present(present), .mod_data_in(mod_data_in),
        .mod_ack_b(mod_ack_b));

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    // Request held until ack is sampled, then dropped
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [15:0] d, input logic ack_exp,
                       output logic [15:0] r);
        logic got;
        got = 1'b0;
        r = 16'h0000;
        lb_req = 1'b1;
        lb_wr = w;
        lb_addr = a;
        lb_wdata = d;
        for (int i = 0; i < 400 && !got; i++) begin
            @(posedge clk);
            if (lb_ack === 1'b1) begin
                got = 1'b1;
                r = lb_rdata;
            end
        end
        #1;
        if (got) begin
            lb_req = 1'b0;
            tick(1);
        end
        chk("completion", 16'(got), 16'(ack_exp));
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        acc(1'b1, a, d, 1'b1, q);
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] e,
                      input string n);
        acc(1'b0, a, 16'h0000, 1'b1, q);
        chk(n, q, e);
    endtask

    task automatic wirq(input logic e);
        for (int i = 0; i < 12 && local_irq !== e; i++) tick(1);
        chk("local_irq", 16'(local_irq), 16'(e));
    endtask

    // Eight slot clock periods, counted in bus clocks
    task automatic rate(input int s, input int e);
        int rises;
        int n;
        logic prev;
        rises = 0;
        n = 0;
        prev = slot_clk[s];
        for (int i = 0; i < 300 && rises < 9; i++) begin
            @(posedge clk);
            if (rises > 0) n++;
            if (slot_clk[s] && !prev) rises++;
            prev = slot_clk[s];
        end
        #1;
        chk("slot clock", 16'(n >= e - 3 && n <= e + 3), 16'h0001);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(2);
        rst_b = 1'b1;
        tick(3);
        rd(16'h0500, {8'h00, CTRL_RESET}, "control reset");
        foreach (rows[i]) begin
            acc(rows[i].w, rows[i].a, rows[i].d, 1'b1, q);
            if (!rows[i].w) chk("register", q, rows[i].e);
        end
        $display("register table done");
        wr(16'h0500, 16'h0040);
        for (int i = 0; i < 8; i++) begin
            mod_irq_b = ~(8'h01 << i);
            tick(6);
            wirq(1'b1);
            rd(16'h0700, 16'h0001, "status");
            rd(16'h0600, 16'(8'h01 << i), "pending");
        end
        wr(16'h0600, 16'h0000);
        rd(16'h0600, 16'h0080, "pending");
        wr(16'h0500, 16'h0000);
        wirq(1'b0);
        rd(16'h0600, 16'h0080, "pending");
        mod_irq_b = 8'hFF;
        tick(6);
        rd(16'h0600, 16'h0000, "pending");
        wr(16'h0500, 16'h0080);
        wirq(1'b0);
        wr(16'h0500, 16'h00C0);
        wirq(1'b1);
        rd(16'h0700, 16'h0001, "status");
        $display("interrupt test done");
        wr(16'h0500, 16'h0009);
        foreach (maddr[i]) begin
            rd(maddr[i], mvec[i], "module data");
        end
        wr(16'h1004, 16'h1234);
        chk("module data out", mod_data_out, 16'h1234);
        wr(16'h0500, 16'h0005);
        tick(30);
        for (int s = 0; s < 4; s++) rate(s, (s % 2 == 0) ? 25 : 100);
        $display("module access test done");
        wr(16'h0500, 16'h0070);
        rd(16'h3200, TIMEOUT_READ_DATA, "timeout data");
        rd(16'h0700, 16'h0003, "status");
        wirq(1'b1);
        wr(16'h0500, 16'h0060);
        wirq(1'b0);
        rd(16'h0700, 16'h0000, "status");
        wr(16'h0500, 16'h0070);
        rd(16'h0700, 16'h0000, "status");
        wr(16'h0500, 16'h0020);
        rd(16'h3000, TIMEOUT_READ_DATA, "timeout data");
        rd(16'h0700, 16'h0000, "status");
        wr(16'h0500, 16'h0030);
        rd(16'h3100, TIMEOUT_READ_DATA, "timeout data");
        rd(16'h0700, 16'h0002, "status");
        wirq(1'b0);
        $display("timeout test done");
        wr(16'h0500, 16'h0000);
        acc(1'b1, 16'h3004, 16'h5555, 1'b0, q);
        lb_req = 1'b0;
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        tick(3);
        rd(16'h0500, {8'h00, CTRL_RESET}, "control reset");
        wr(16'h0500, 16'h0030);
        acc(1'b0, 16'h0800, 16'h0000, 1'b0, q);
        $display("stuck access test done");
        give_verdict();
    end
endmodule // tb
